// ===== hw/tcpwm_channel.sv
// compare/pwm channel top: apb registers, compare logic and output stage
//
// Function
// - on match, mode 000 holds, 001 sets, 010 clears, 011 toggles the output
// - counter equal to compare value sets the compare flag
// - interrupt request on match only when the compare irq enable is set
// - polarity select sets output active level; reference is active high
// - compare value direct when preload off, else moved on update event
// - update event does not touch reference or output in non-pwm modes
// - matches resolved to a single counter count
// - mode 110 is pwm mode 1, 111 is pwm mode 2
// - auto-reload value may be buffered through a preload stage
// - preloads reach shadows only on update; software sets update_generate first
// - output enable from channel enable, main enable, idle and off-state selects
// - pwm compares counter and compare value continuously, by direction
// - direction low counts up, high counts down in edge-aligned mode
// - up pwm1: high while counter below compare; 1 above reload, 0 at zero
// - down pwm1: low while counter above compare; 1 above reload
// - center-aligned when center select nonzero; same waveform for all
// - center flag: 01 down only, 10 up only, 11 both directions
// - center mode direction is driven by hardware; writes ignored
// - mode 101 forces reference high; output level from polarity
// - mode 100 forces reference low; flags and interrupts still work
`timescale 1ns/1ps
`default_nettype none
`include "tcpwm_defines.svh"
module tcpwm_channel (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o,
  output logic             reference_wave_o,
  output logic             channel_output_o,
  output logic             channel_output_en_o
);

  // --------------------------------------------------------------
  // apb handshake
  // --------------------------------------------------------------
  // one wait state keeps prdata straight from a flip-flop
  wire acc_w  = psel_i & penable_i;
  wire done_w = acc_w & pready_o;
  wire wr_w   = done_w & pwrite_i;

  wire sel_ctrl_w   = (paddr_i == `TCPWM_OFS_CTRL);
  wire sel_evgen_w  = (paddr_i == `TCPWM_OFS_EVGEN);
  wire sel_status_w = (paddr_i == `TCPWM_OFS_STATUS);
  wire sel_irqen_w  = (paddr_i == `TCPWM_OFS_IRQEN);
  wire sel_chmode_w = (paddr_i == `TCPWM_OFS_CHMODE);
  wire sel_chen_w   = (paddr_i == `TCPWM_OFS_CHEN);
  wire sel_break_w  = (paddr_i == `TCPWM_OFS_BREAK);
  wire sel_count_w  = (paddr_i == `TCPWM_OFS_COUNT);
  wire sel_reload_w = (paddr_i == `TCPWM_OFS_RELOAD);
  wire sel_cmp_w    = (paddr_i == `TCPWM_OFS_COMPARE);

  wire mapped_w = sel_ctrl_w | sel_evgen_w | sel_status_w | sel_irqen_w
                | sel_chmode_w | sel_chen_w | sel_break_w | sel_count_w
                | sel_reload_w | sel_cmp_w;

  wire wr_ctrl_w   = wr_w & sel_ctrl_w;
  wire wr_evgen_w  = wr_w & sel_evgen_w;
  wire wr_status_w = wr_w & sel_status_w;
  wire wr_irqen_w  = wr_w & sel_irqen_w;
  wire wr_chmode_w = wr_w & sel_chmode_w;
  wire wr_chen_w   = wr_w & sel_chen_w;
  wire wr_break_w  = wr_w & sel_break_w;
  wire wr_reload_w = wr_w & sel_reload_w;
  wire wr_cmp_w    = wr_w & sel_cmp_w;

  // --------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] irqen_r;
  logic [7:0] chmode_r;
  logic [7:0] chen_r;
  logic [7:0] break_r;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctrl_r   <= `TCPWM_RST_REG8;
      irqen_r  <= `TCPWM_RST_REG8;
      chmode_r <= `TCPWM_RST_REG8;
      chen_r   <= `TCPWM_RST_REG8;
      break_r  <= `TCPWM_RST_REG8;
    end else begin
      if (wr_ctrl_w) begin
        ctrl_r <= pwdata_i[7:0];
      end
      if (wr_irqen_w) begin
        irqen_r <= pwdata_i[7:0];
      end
      if (wr_chmode_w) begin
        chmode_r <= pwdata_i[7:0];
      end
      if (wr_chen_w) begin
        chen_r <= pwdata_i[7:0];
      end
      if (wr_break_w) begin
        break_r <= pwdata_i[7:0];
      end
    end
  end

  // --------------------------------------------------------------
  // named control bits
  // --------------------------------------------------------------
  wire       counter_run_w           = ctrl_r[`TCPWM_CTRL_RUN];
  wire       sw_dir_w                = ctrl_r[`TCPWM_CTRL_DIR];
  wire [1:0] center_mode_select_w    = ctrl_r[`TCPWM_CTRL_CMS_HI:`TCPWM_CTRL_CMS_LO];
  wire       reload_preload_enable_w = ctrl_r[`TCPWM_CTRL_RELOAD_PRELOAD_ENABLE];

  wire       compare_preload_enable_w = chmode_r[`TCPWM_MODE_PE];
  wire [2:0] compare_mode_field_w     = chmode_r[`TCPWM_MODE_HI:`TCPWM_MODE_LO];

  wire channel_output_enable_w = chen_r[`TCPWM_CHEN_CCE];
  wire polarity_select_w       = chen_r[`TCPWM_CHEN_POL];

  wire main_output_enable_w   = break_r[`TCPWM_BRK_MOE];
  wire run_offstate_select_w  = break_r[`TCPWM_BRK_RUN_OFFSTATE_SELECT];
  wire idle_offstate_select_w = break_r[`TCPWM_BRK_IDLE_OFFSTATE_SELECT];
  wire idle_state_select_w    = break_r[`TCPWM_BRK_OIS];

  wire compare_irq_enable_w = irqen_r[`TCPWM_ST_CCF];
  wire update_irq_enable_w  = irqen_r[`TCPWM_ST_UIF];

  // event generation bits are self-clearing strobes
  wire update_generate_w  = wr_evgen_w & pwdata_i[`TCPWM_EVGEN_UG];
  wire compare_generate_w = wr_evgen_w & pwdata_i[`TCPWM_EVGEN_CCG];

  tcpwm_pkg::tcpwm_mode_t mode_w;
  assign mode_w = tcpwm_pkg::tcpwm_mode_t'(compare_mode_field_w);

  // --------------------------------------------------------------
  // counter and preload stages
  // --------------------------------------------------------------
  tcpwm_pkg::tcpwm_cnt_cfg_t cnt_cfg_w;
  assign cnt_cfg_w.run = counter_run_w;
  assign cnt_cfg_w.dir = sw_dir_w;
  assign cnt_cfg_w.center_mode_select = center_mode_select_w;

  logic [15:0] counter_value_w;
  logic        count_down_w;
  logic        update_event_w;
  logic [15:0] reload_pre_w;
  logic [15:0] reload_sh_w;
  logic [15:0] compare_pre_w;
  logic [15:0] compare_sh_w;

  tcpwm_counter u_counter (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .cfg_i     (cnt_cfg_w),
    .arr_i     (reload_sh_w),
    .ug_i      (update_generate_w),
    .cnt_o     (counter_value_w),
    .dir_o     (count_down_w),
    .uev_o     (update_event_w)
  );

  tcpwm_shadow #(
    .RST_VAL (`TCPWM_RST_RELOAD)
  ) u_reload (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (wr_reload_w),
    .wdata_i   (pwdata_i[15:0]),
    .pe_i      (reload_preload_enable_w),
    .uev_i     (update_event_w),
    .preload_o (reload_pre_w),
    .shadow_o  (reload_sh_w)
  );

  tcpwm_shadow #(
    .RST_VAL (`TCPWM_RST_COMPARE)
  ) u_compare (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (wr_cmp_w),
    .wdata_i   (pwdata_i[15:0]),
    .pe_i      (compare_preload_enable_w),
    .uev_i     (update_event_w),
    .preload_o (compare_pre_w),
    .shadow_o  (compare_sh_w)
  );

  // --------------------------------------------------------------
  // compare decisions
  // --------------------------------------------------------------
  // counter moves once a clock, so an equal value lasts one count
  wire center_w = (center_mode_select_w != `TCPWM_CMS_EDGE);
  wire equal_w  = (counter_value_w == compare_sh_w);
  wire match_w  = counter_run_w & equal_w;

  // center 01 flags going down, 10 going up, 11 both
  wire dir_ok_w = !center_w
                | (center_mode_select_w == `TCPWM_CMS_DOWN &  count_down_w)
                | (center_mode_select_w == `TCPWM_CMS_UP   & !count_down_w)
                | (center_mode_select_w == 2'h3);
  wire flag_evt_w = (match_w & dir_ok_w) | compare_generate_w;

  // unsigned compare picked by current direction
  wire below_w    = (counter_value_w <  compare_sh_w);
  wire below_eq_w = (counter_value_w <= compare_sh_w);
  wire pwm1_w     = count_down_w ? below_eq_w : below_w;

  // --------------------------------------------------------------
  // reference waveform
  // --------------------------------------------------------------
  logic ref_r;
  logic ref_nxt;

  always_comb begin
    ref_nxt = ref_r;
    case (mode_w)
      tcpwm_pkg::TCPWM_FROZEN:   ref_nxt = ref_r;
      tcpwm_pkg::TCPWM_SET_ACT:  ref_nxt = match_w ? 1'b1 : ref_r;
      tcpwm_pkg::TCPWM_SET_INA:  ref_nxt = match_w ? 1'b0 : ref_r;
      tcpwm_pkg::TCPWM_TOGGLE:   ref_nxt = ref_r ^ match_w;
      tcpwm_pkg::TCPWM_FORCE_LO: ref_nxt = 1'b0;
      tcpwm_pkg::TCPWM_FORCE_HI: ref_nxt = 1'b1;
      tcpwm_pkg::TCPWM_PWM1:     ref_nxt = pwm1_w;
      tcpwm_pkg::TCPWM_PWM2:     ref_nxt = !pwm1_w;
      default:                   ref_nxt = ref_r;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ref_r <= 1'b0;
    end else begin
      ref_r <= ref_nxt;
    end
  end

  // --------------------------------------------------------------
  // output stage
  // --------------------------------------------------------------
  // polarity acts at the end of the chain; reference stays active high
  wire active_lvl_w = ref_r ^ polarity_select_w;
  wire off_lvl_w    = polarity_select_w;

  logic out_nxt;
  logic oe_nxt;

  always_comb begin
    out_nxt = 1'b0;
    oe_nxt  = 1'b0;
    if (main_output_enable_w) begin
      if (channel_output_enable_w) begin
        out_nxt = active_lvl_w;
        oe_nxt  = 1'b1;
      end else if (run_offstate_select_w) begin
        out_nxt = off_lvl_w;
        oe_nxt  = 1'b1;
      end
    end else if (idle_offstate_select_w) begin
      out_nxt = idle_state_select_w;
      oe_nxt  = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      reference_wave_o    <= 1'b0;
      channel_output_o    <= 1'b0;
      channel_output_en_o <= 1'b0;
    end else begin
      reference_wave_o    <= ref_r;
      channel_output_o    <= out_nxt;
      channel_output_en_o <= oe_nxt;
    end
  end

  // --------------------------------------------------------------
  // status flags and interrupt request
  // --------------------------------------------------------------
  // write 0 clears; a new event in the same cycle wins
  logic uif_r;
  logic ccf_r;

  wire clr_uif_w = wr_status_w & !pwdata_i[`TCPWM_ST_UIF];
  wire clr_ccf_w = wr_status_w & !pwdata_i[`TCPWM_ST_CCF];

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      uif_r <= 1'b0;
      ccf_r <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      uif_r <= update_event_w | (uif_r & !clr_uif_w);
      ccf_r <= flag_evt_w | (ccf_r & !clr_ccf_w);
      irq_o <= (ccf_r & compare_irq_enable_w)
             | (uif_r & update_irq_enable_w);
    end
  end

  // --------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------
  // direction bit reads the hardware direction in center mode
  wire [7:0] ctrl_rd_w = {ctrl_r[7:5], (center_w ? count_down_w : sw_dir_w),
                          ctrl_r[3:0]};
  wire [7:0] status_rd_w = {6'h00, ccf_r, uif_r};

  wire [31:0] rd_w = sel_ctrl_w   ? {24'h000000, ctrl_rd_w}      :
                     sel_status_w ? {24'h000000, status_rd_w}    :
                     sel_irqen_w  ? {24'h000000, irqen_r}        :
                     sel_chmode_w ? {24'h000000, chmode_r}       :
                     sel_chen_w   ? {24'h000000, chen_r}         :
                     sel_break_w  ? {24'h000000, break_r}        :
                     sel_count_w  ? {16'h0000, counter_value_w}  :
                     sel_reload_w ? {16'h0000, reload_pre_w}     :
                     sel_cmp_w    ? {16'h0000, compare_pre_w}    :
                                    32'h00000000;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= acc_w & !pready_o;
      pslverr_o <= acc_w & !pready_o & !mapped_w;
      if (acc_w & !pready_o & !pwrite_i) begin
        prdata_o <= rd_w;
      end
    end
  end

endmodule : tcpwm_channel
`default_nettype wire

// ===== hw/tcpwm_counter.sv
// 16-bit up, down and center-aligned counter with update event
`timescale 1ns/1ps
`default_nettype none
`include "tcpwm_defines.svh"
module tcpwm_counter (
  input  wire logic                    clock_i,
  input  wire logic                    sys_rst_i,
  input  wire tcpwm_pkg::tcpwm_cnt_cfg_t cfg_i,
  input  wire logic [15:0]             arr_i,
  input  wire logic                    ug_i,
  output logic      [15:0]             cnt_o,
  output logic                         dir_o,
  output logic                         uev_o
);
  wire center_w = (cfg_i.center_mode_select != `TCPWM_CMS_EDGE);
  wire down_w   = center_w ? dir_o : cfg_i.dir;
  wire top_w    = (cnt_o >= arr_i);
  wire bot_w    = (cnt_o == 16'h0000);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cnt_o <= 16'h0000;
      dir_o <= 1'b0;
      uev_o <= 1'b0;
    end else begin
      uev_o <= 1'b0;
      if (!center_w) begin
        dir_o <= cfg_i.dir;
      end
      if (ug_i) begin
        cnt_o <= (!center_w && cfg_i.dir) ? arr_i : 16'h0000;
        uev_o <= 1'b1;
      end else if (cfg_i.run) begin
        if (!down_w && top_w) begin
          cnt_o <= center_w ? arr_i - 16'h0001 : 16'h0000;
          dir_o <= center_w;
          uev_o <= 1'b1;
        end else if (down_w && bot_w) begin
          cnt_o <= center_w ? 16'h0001 : arr_i;
          dir_o <= !center_w;
          uev_o <= 1'b1;
        end else begin
          cnt_o <= down_w ? cnt_o - 16'h0001 : cnt_o + 16'h0001;
        end
      end
    end
  end
endmodule : tcpwm_counter
`default_nettype wire

// ===== hw/tcpwm_defines.svh
// register offsets, field positions and reset values of the compare/pwm channel
`ifndef TCPWM_DEFINES_SVH
`define TCPWM_DEFINES_SVH
`define TCPWM_OFS_CTRL      12'h000
`define TCPWM_OFS_EVGEN     12'h004
`define TCPWM_OFS_STATUS    12'h008
`define TCPWM_OFS_IRQEN     12'h00C
`define TCPWM_OFS_CHMODE    12'h010
`define TCPWM_OFS_CHEN      12'h014
`define TCPWM_OFS_BREAK     12'h018
`define TCPWM_OFS_COUNT     12'h01C
`define TCPWM_OFS_RELOAD    12'h020
`define TCPWM_OFS_COMPARE   12'h024
`define TCPWM_CTRL_RUN      0
`define TCPWM_CTRL_DIR      4
`define TCPWM_CTRL_CMS_LO   5
`define TCPWM_CTRL_CMS_HI   6
`define TCPWM_CTRL_RELOAD_PRELOAD_ENABLE     7
`define TCPWM_EVGEN_UG      0
`define TCPWM_EVGEN_CCG     1
`define TCPWM_ST_UIF        0
`define TCPWM_ST_CCF        1
`define TCPWM_MODE_PE       3
`define TCPWM_MODE_LO       4
`define TCPWM_MODE_HI       6
`define TCPWM_CHEN_CCE      0
`define TCPWM_CHEN_POL      1
`define TCPWM_BRK_OIS       0
`define TCPWM_BRK_IDLE_OFFSTATE_SELECT      2
`define TCPWM_BRK_RUN_OFFSTATE_SELECT      3
`define TCPWM_BRK_MOE       7
`define TCPWM_RST_REG8      8'h00
`define TCPWM_RST_RELOAD    16'hFFFF
`define TCPWM_RST_COMPARE   16'h0000
`define TCPWM_CMS_EDGE      2'h0
`define TCPWM_CMS_DOWN      2'h1
`define TCPWM_CMS_UP        2'h2
`endif

// ===== hw/tcpwm_pkg.sv
// types shared by the compare/pwm channel files
package tcpwm_pkg;

  typedef enum logic [2:0] {
    TCPWM_FROZEN   = 3'h0,
    TCPWM_SET_ACT  = 3'h1,
    TCPWM_SET_INA  = 3'h2,
    TCPWM_TOGGLE   = 3'h3,
    TCPWM_FORCE_LO = 3'h4,
    TCPWM_FORCE_HI = 3'h5,
    TCPWM_PWM1     = 3'h6,
    TCPWM_PWM2     = 3'h7
  } tcpwm_mode_t;

  typedef struct packed {
    logic       run;
    logic       dir;
    logic [1:0] center_mode_select;
  } tcpwm_cnt_cfg_t;

endpackage : tcpwm_pkg

// ===== hw/tcpwm_shadow.sv
// preload register with a shadow copy moved on update events
`timescale 1ns/1ps
`default_nettype none
module tcpwm_shadow #(
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        pe_i,
  input  wire logic        uev_i,
  output logic      [15:0] preload_o,
  output logic      [15:0] shadow_o
);
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      preload_o <= RST_VAL;
      shadow_o  <= RST_VAL;
    end else begin
      if (wr_i) begin
        preload_o <= wdata_i;
      end
      if (wr_i && !pe_i) begin
        shadow_o <= wdata_i;
      end else if (uev_i) begin
        shadow_o <= preload_o;
      end
    end
  end
endmodule : tcpwm_shadow
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the compare/pwm channel
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ------------------------------------------------
  // signals and instances
  // ------------------------------------------------
  typedef struct packed {
    logic [2:0]  mode;
    logic        dir;
    logic [1:0]  center_mode_select;
    logic [15:0] ccr;
    logic [7:0]  hi;
  } tcpwm_row_t;

  logic        clock_i;
  logic        sys_rst_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        irq_o;
  logic        reference_wave_o;
  logic        channel_output_o;
  logic        channel_output_en_o;
  logic        pin;
  logic [31:0] q;
  logic        e;
  logic        v;
  int          h;
  int          err_total;
  int          tests_run;
  tcpwm_row_t  rows [11];
  logic [17:0] stg [4];

  tcpwm_channel u_tcpwm_channel (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
    .reference_wave_o(reference_wave_o), .channel_output_o(channel_output_o),
    .channel_output_en_o(channel_output_en_o)
  );
  tcpwm_pin_model u_tcpwm_pin_model (.drive_i(channel_output_en_o), .level_i(channel_output_o),
    .pin_o(pin));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    q = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // counts high cycles, or level changes when tog is set
  task automatic meas(input int n, input logic tog);
    logic p;
    h = 0;
    p = reference_wave_o;
    repeat (n) begin
      @(posedge clock_i);
      if (tog ? (reference_wave_o !== p) : (reference_wave_o === 1'b1)) h++;
      p = reference_wave_o;
    end
  endtask : meas

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (12000) @(posedge clock_i);
    err_total++;
    end_sim();
  end

  // ------------------------------------------------
  // sequence
  // ------------------------------------------------
  initial begin
    sys_rst_i = 1'b1;
    psel_i    = 1'b0;
    penable_i = 1'b0;
    pwrite_i  = 1'b0;
    paddr_i   = 12'h000;
    pwdata_i  = 32'h0;
    err_total = 0;
    tests_run = 0;
    // high cycles per period with reload 8
    rows = '{'{3'h6, 1'b0, 2'h0, 16'h0003, 8'h03},
             '{3'h6, 1'b0, 2'h0, 16'h0000, 8'h00},
             '{3'h6, 1'b0, 2'h0, 16'h0009, 8'h09},
             '{3'h6, 1'b0, 2'h0, 16'h8000, 8'h09},
             '{3'h7, 1'b0, 2'h0, 16'h0003, 8'h06},
             '{3'h6, 1'b1, 2'h0, 16'h0003, 8'h04},
             '{3'h6, 1'b1, 2'h0, 16'hFFFF, 8'h09},
             '{3'h7, 1'b1, 2'h0, 16'h0003, 8'h05},
             '{3'h6, 1'b0, 2'h1, 16'h0003, 8'h06},
             '{3'h6, 1'b0, 2'h2, 16'h0003, 8'h06},
             '{3'h6, 1'b1, 2'h3, 16'h0003, 8'h06}};
    // channel enable, break bits, then expected drive enable and pin
    stg = '{{8'h02, 8'h88, 2'h3}, {8'h02, 8'h80, 2'h0}, {8'h03, 8'h05, 2'h3}, {8'h03, 8'h00, 2'h0}};
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;

    rd(12'h020);
    chk(q, 32'h0000FFFF);
    rd(12'h024);
    chk(q, 32'h0);
    wr(12'h01C, 32'h5);
    rd(12'h01C);
    chk(q, 32'h0);
    rd(12'h028);
    chk({q[30:0], e}, 32'h1);
    $display("test reset_and_map finished");

    wr(12'h018, 32'h80);
    wr(12'h014, 32'h1);
    foreach (rows[i]) begin
      wr(12'h000, 32'h0);
      wr(12'h020, 32'h8);
      wr(12'h010, {25'h0, rows[i].mode, 4'h8});
      wr(12'h024, {16'h0, rows[i].ccr});
      wr(12'h004, 32'h1);
      wr(12'h000, {25'h0, rows[i].center_mode_select, rows[i].dir, 4'h1});
      repeat (4) @(posedge clock_i);
      meas(rows[i].center_mode_select != 2'h0 ? 32 : 18, 1'b0);
      chk(h, 32'(rows[i].hi) * 2);
    end
    $display("test pwm_table finished");

    wr(12'h000, 32'h0);
    wr(12'h020, 32'hFFFF);
    wr(12'h010, 32'h68);
    wr(12'h024, 32'h0);
    wr(12'h004, 32'h1);
    wr(12'h000, 32'h1);
    wr(12'h024, 32'h1000);
    chk({31'h0, reference_wave_o}, 32'h0);
    wr(12'h004, 32'h1);
    repeat (4) @(posedge clock_i);
    chk({31'h0, reference_wave_o}, 32'h1);
    wr(12'h010, 32'h60);
    wr(12'h024, 32'h0);
    repeat (4) @(posedge clock_i);
    chk({31'h0, reference_wave_o}, 32'h0);
    $display("test preload finished");

    wr(12'h000, 32'h0);
    wr(12'h020, 32'h8);
    wr(12'h010, 32'h40);
    wr(12'h024, 32'h5);
    wr(12'h00C, 32'h2);
    wr(12'h008, 32'h0);
    wr(12'h004, 32'h1);
    wr(12'h000, 32'h1);
    repeat (12) @(posedge clock_i);
    rd(12'h008);
    chk(q & 32'h2, 32'h2);
    chk({31'h0, irq_o}, 32'h1);
    for (int k = 0; k < 3; k++) begin
      wr(12'h010, {25'h0, k == 0 ? 3'h1 : k == 1 ? 3'h0 : 3'h2, 4'h0});
      repeat (12) @(posedge clock_i);
      chk({31'h0, reference_wave_o}, {31'h0, k < 2});
    end
    wr(12'h010, 32'h30);
    repeat (4) @(posedge clock_i);
    meas(36, 1'b1);
    chk(h, 32'h4);
    wr(12'h000, 32'h0);
    wr(12'h00C, 32'h0);
    v = reference_wave_o;
    wr(12'h004, 32'h1);
    repeat (4) @(posedge clock_i);
    chk({31'h0, reference_wave_o}, {31'h0, v});
    $display("test compare_modes finished");

    // compare value equal to reload is reached only while counting up
    for (int k = 1; k < 3; k++) begin
      wr(12'h000, 32'h0);
      wr(12'h024, 32'h8);
      wr(12'h008, 32'h0);
      wr(12'h000, {25'h0, 2'(k), 5'h01});
      repeat (40) @(posedge clock_i);
      rd(12'h008);
      chk(q & 32'h2, {30'h0, k == 2, 1'b0});
    end
    wr(12'h000, 32'h0);
    wr(12'h008, 32'h0);
    wr(12'h004, 32'h2);
    rd(12'h008);
    chk(q & 32'h2, 32'h2);
    $display("test center_flags finished");

    wr(12'h010, 32'h50);
    wr(12'h014, 32'h3);
    repeat (4) @(posedge clock_i);
    chk({30'h0, reference_wave_o, pin}, 32'h2);
    foreach (stg[i]) begin
      wr(12'h014, {24'h0, stg[i][17:10]});
      wr(12'h018, {24'h0, stg[i][9:2]});
      repeat (4) @(posedge clock_i);
      chk({30'h0, channel_output_en_o, pin}, {30'h0, stg[i][1:0]});
    end
    $display("test output_stage finished");
    end_sim();
  end
endmodule : tb
`default_nettype wire

// ===== sim/tcpwm_monitor.sv
// port-level assertions for the compare/pwm channel
`timescale 1ns/1ps
`default_nettype none
module tcpwm_monitor (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  input  wire logic        irq_o,
  input  wire logic        reference_wave_o,
  input  wire logic        channel_output_o,
  input  wire logic        channel_output_en_o
);
  // ------------------------------------------------
  // configuration seen on the bus
  // ------------------------------------------------
  logic [10:0] cfg_r;
  logic [10:0] cfg_d;
  wire  logic  wr_ok = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
  wire  logic  cce   = cfg_d[0];
  wire  logic  pol   = cfg_d[1];
  wire  logic  ois   = cfg_d[2];
  wire  logic  idle_offstate_select  = cfg_d[3];
  wire  logic  run_offstate_select  = cfg_d[4];
  wire  logic  main_output_enable   = cfg_d[5];

  // delayed copy because the output stage is registered once more
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cfg_r <= 11'h000;
      cfg_d <= 11'h000;
    end else begin
      cfg_d <= cfg_r;
      if (wr_ok && paddr_i == 12'h014) cfg_r[1:0] <= pwdata_i[1:0];
      if (wr_ok && paddr_i == 12'h018) cfg_r[5:2] <= {pwdata_i[7], pwdata_i[3:2], pwdata_i[0]};
      if (wr_ok && paddr_i == 12'h00C) cfg_r[7:6] <= pwdata_i[1:0];
      if (wr_ok && paddr_i == 12'h010) cfg_r[10:8] <= pwdata_i[6:4];
    end
  end

  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  ready_wait_a: assert property ((psel_i && !penable_i) ##1 (psel_i && penable_i) |=> pready_o)
    else $error("pready not in second access cycle");
  ready_cause_a: assert property (pready_o |-> psel_i && penable_i && $past(psel_i && penable_i))
    else $error("pready without access phase");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  out_polarity_a: assert property (main_output_enable && cce |->
    channel_output_en_o && channel_output_o == (reference_wave_o ^ pol))
    else $error("driven output not reference xor polarity");
  run_offstate_a: assert property (main_output_enable && !cce |->
    channel_output_en_o == run_offstate_select && (!run_offstate_select || channel_output_o == pol))
    else $error("run off-state drive wrong");
  idle_level_a: assert property (!main_output_enable |->
    channel_output_en_o == idle_offstate_select && channel_output_o == (idle_offstate_select & ois))
    else $error("idle drive wrong");
  irq_gate_a: assert property (cfg_d[7:6] == 2'h0 |-> !irq_o)
    else $error("irq with enables clear");
  force_high_a: assert property ((cfg_d[10:8] == 3'h5) [*2] |-> reference_wave_o)
    else $error("forced high reference low");
  force_low_a: assert property ((cfg_d[10:8] == 3'h4) [*2] |-> !reference_wave_o)
    else $error("forced low reference high");
endmodule : tcpwm_monitor

bind tcpwm_channel tcpwm_monitor u_tcpwm_monitor (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
  .reference_wave_o(reference_wave_o), .channel_output_o(channel_output_o),
  .channel_output_en_o(channel_output_en_o)
);
`default_nettype wire

// ===== sim/tcpwm_pin_model.sv
// pin load model for the channel output, with a weak pull-down
`timescale 1ns/1ps
`default_nettype none
module tcpwm_pin_model #(
  parameter logic PULL = 1'b0
) (
  input  wire logic drive_i,
  input  wire logic level_i,
  output logic      pin_o
);
  // ------------------------------------------------
  // pin level
  // ------------------------------------------------
  // a released pin shows the pull level, never the last driven value
  assign pin_o = (drive_i === 1'b1) ? level_i : PULL;
endmodule : tcpwm_pin_model
`default_nettype wire
